// file: inc/qrbsp_pkg.sv
// constants and types shared by the quad-rate burst sram port
package qrbsp_pkg;

   // data word width, wide configuration (narrow configuration uses 18)
   localparam int DATA_W_DEF = 36;
   // burst address width, wide configuration: 2M words / 4 words per burst
   localparam int ADDR_W_DEF = 19;
   // words moved per address
   localparam int BURST_LEN = 4;
   // stages of every two-flop synchroniser
   localparam int SYNC_STAGES = 2;

   // reset values of the registered pins and the output side
   localparam logic SEL_N_RST = 1'b1;
   localparam logic ECHO_RST = 1'b0;
   localparam logic VALID_RST = 1'b0;

   // word positions inside a burst, word 0 leaves or arrives first
   localparam int WORD0 = 0;
   localparam int WORD1 = 1;
   localparam int WORD2 = 2;
   localparam int WORD3 = 3;

   // depth of the read burst history, deep enough for the long latency
   localparam int HIST_DEPTH = 3;

   // which kind of address the shared bus carried at a true-clock edge
   typedef enum logic [1:0] {
      QRBSP_SLOT_RD = 2'b01,
      QRBSP_SLOT_WR = 2'b10
   } qrbsp_slot_t;

   // slot held in the address register right after reset
   localparam qrbsp_slot_t SLOT_RST = QRBSP_SLOT_RD;

endpackage

// file: hdl/qrbsp_top.sv
// burst sram port: shared address bus, ddr read and write ports, memory array
`timescale 1ns/10ps
`default_nettype none
module qrbsp_top #(
   parameter int DATA_W = qrbsp_pkg::DATA_W_DEF,
   parameter int ADDR_W = qrbsp_pkg::ADDR_W_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic k_clk,
   input wire logic kn_clk,
   input wire logic [ADDR_W-1:0] addr_bus,
   input wire logic read_sel_n,
   input wire logic write_sel_n,
   input wire logic [DATA_W-1:0] write_data,
   input wire logic latency_select_pin,
   output logic [DATA_W-1:0] read_data_k,
   output logic [DATA_W-1:0] read_data_kn,
   output logic echo_timing_out,
   output logic echo_timing_out_n,
   output logic read_valid_flag,
   output logic read_done,
   output logic write_done
);
   import qrbsp_pkg::*;

   localparam int BW = BURST_LEN * DATA_W;

   // state of the true-clock domain
   typedef struct packed {
      logic [SYNC_STAGES-1:0] rst_sync;
      logic [SYNC_STAGES-1:0] lat_sync;
      qrbsp_slot_t slot;
      logic [ADDR_W-1:0] addr;
      logic rd_sel_n;
      logic wr_sel_n;
      logic [DATA_W-1:0] din;
      logic wr_pend;
      logic [ADDR_W-1:0] wr_addr;
      logic [DATA_W-1:0] w0;
      logic [DATA_W-1:0] w1;
      logic [HIST_DEPTH-1:0][BW-1:0] hist;
      logic [HIST_DEPTH-1:0] hv;
      logic [DATA_W-1:0] qk;
      logic [DATA_W-1:0] stg;
      logic stg_v;
      logic echo;
      logic rd_tgl;
      logic wr_tgl;
   } qrbsp_k_t;

   // state of the complementary-clock domain
   typedef struct packed {
      logic [SYNC_STAGES-1:0] rst_sync;
      logic [DATA_W-1:0] din;
      logic [DATA_W-1:0] qkn;
      logic valid;
      logic echo;
   } qrbsp_kn_t;

   // state of the system-clock domain
   typedef struct packed {
      logic [SYNC_STAGES:0] rd_sync;
      logic [SYNC_STAGES:0] wr_sync;
      logic rd_pulse;
      logic wr_pulse;
   } qrbsp_sys_t;

   qrbsp_k_t k_ff;
   qrbsp_k_t nxt_k;
   qrbsp_kn_t kn_ff;
   qrbsp_kn_t nxt_kn;
   qrbsp_sys_t sys_ff;
   qrbsp_sys_t nxt_sys;

   // the array itself, one burst per entry
   logic [BW-1:0] mem_arr [0:(1<<ADDR_W)-1];

   logic k_rst;
   logic kn_rst;
   logic lat_long;
   logic rd_take;
   logic wr_take;
   logic wr_hit;
   logic [BW-1:0] wr_burst;
   logic [BW-1:0] rd_burst;

   // decoded controls of the true-clock domain, plus the complementary-clock reset
   assign k_rst = k_ff.rst_sync[SYNC_STAGES-1];
   assign kn_rst = kn_ff.rst_sync[SYNC_STAGES-1];
   assign lat_long = k_ff.lat_sync[SYNC_STAGES-1];
   assign rd_take = (k_ff.slot == QRBSP_SLOT_RD) && !k_ff.rd_sel_n;
   assign wr_take = (k_ff.slot == QRBSP_SLOT_WR) && !k_ff.wr_sel_n;

   // full write burst: words 2 and 3 arrive on the edge pair after capture
   assign wr_burst = {kn_ff.din, k_ff.din, k_ff.w1, k_ff.w0};
   // a read of the address being written gets the new burst
   assign wr_hit = k_ff.wr_pend && (k_ff.wr_addr == k_ff.addr);
   assign rd_burst = wr_hit ? wr_burst : mem_arr[k_ff.addr];

   // true-clock next state
   always_comb begin
      nxt_k = k_ff;
      // reset level and latency pin each pass two flops
      nxt_k.rst_sync = {k_ff.rst_sync[SYNC_STAGES-2:0], rst};
      nxt_k.lat_sync = {k_ff.lat_sync[SYNC_STAGES-2:0], latency_select_pin};
      // input registers on the true clock
      nxt_k.addr = addr_bus;
      nxt_k.rd_sel_n = read_sel_n;
      nxt_k.wr_sel_n = write_sel_n;
      nxt_k.din = write_data;
      // address kinds alternate edge by edge on the shared bus
      nxt_k.slot = (k_ff.slot == QRBSP_SLOT_RD) ? QRBSP_SLOT_WR : QRBSP_SLOT_RD;
      // write capture: word 0 on this true rise, word 1 on the next complementary rise
      nxt_k.wr_pend = wr_take;
      if (wr_take) begin
         nxt_k.wr_addr = k_ff.addr;
         nxt_k.w0 = k_ff.din;
         nxt_k.w1 = kn_ff.din;
      end
      // read bursts age through the history, one stage per edge
      nxt_k.hist = {k_ff.hist[HIST_DEPTH-2:0], rd_burst};
      nxt_k.hv = {k_ff.hv[HIST_DEPTH-2:0], rd_take};
      // output word schedule
      if (lat_long) begin
         // words leave at +2.5, +3, +3.5, +4 cycles
         nxt_k.stg_v = k_ff.hv[0] || k_ff.hv[1];
         if (k_ff.hv[0]) begin
            nxt_k.stg = k_ff.hist[0][WORD0*DATA_W +: DATA_W];
         end else begin
            nxt_k.stg = k_ff.hist[1][WORD2*DATA_W +: DATA_W];
         end
         if (k_ff.hv[1]) begin
            nxt_k.qk = k_ff.hist[1][WORD1*DATA_W +: DATA_W];
         end else if (k_ff.hv[2]) begin
            nxt_k.qk = k_ff.hist[2][WORD3*DATA_W +: DATA_W];
         end
      end else begin
         // words leave at +1, +1.5, +2, +2.5 cycles
         nxt_k.stg_v = rd_take || k_ff.hv[0];
         if (rd_take) begin
            nxt_k.qk = rd_burst[WORD0*DATA_W +: DATA_W];
            nxt_k.stg = rd_burst[WORD1*DATA_W +: DATA_W];
         end else if (k_ff.hv[0]) begin
            nxt_k.qk = k_ff.hist[0][WORD2*DATA_W +: DATA_W];
            nxt_k.stg = k_ff.hist[0][WORD3*DATA_W +: DATA_W];
         end
      end
      // echo follows the true clock at half rate, one change per rise
      nxt_k.echo = !k_ff.echo;
      // completion events, handed to the system clock as toggles
      nxt_k.rd_tgl = k_ff.rd_tgl ^ rd_take;
      nxt_k.wr_tgl = k_ff.wr_tgl ^ k_ff.wr_pend;
      if (k_rst) begin
         nxt_k = '0;
         nxt_k.rst_sync = {k_ff.rst_sync[SYNC_STAGES-2:0], rst};
         nxt_k.slot = SLOT_RST;
         nxt_k.rd_sel_n = SEL_N_RST;
         nxt_k.wr_sel_n = SEL_N_RST;
         nxt_k.echo = ECHO_RST;
      end
   end

   // true-clock registers, rising edge only
   always_ff @(posedge k_clk) begin
      k_ff <= nxt_k;
   end

   // self-timed commit of a whole burst one edge after word 3
   always_ff @(posedge k_clk) begin
      if (k_ff.wr_pend && !k_rst) begin
         mem_arr[k_ff.wr_addr] <= wr_burst;
      end
   end

   // complementary-clock next state
   always_comb begin
      nxt_kn = kn_ff;
      // reset follows the true-clock reset through two flops
      nxt_kn.rst_sync = {kn_ff.rst_sync[SYNC_STAGES-2:0], k_rst};
      nxt_kn.din = write_data;
      // stage word prepared half a cycle earlier on the true clock
      nxt_kn.qkn = k_ff.stg;
      nxt_kn.valid = k_ff.stg_v;
      nxt_kn.echo = !kn_ff.echo;
      if (kn_rst) begin
         nxt_kn = '0;
         nxt_kn.rst_sync = {kn_ff.rst_sync[SYNC_STAGES-2:0], k_rst};
         nxt_kn.valid = VALID_RST;
         nxt_kn.echo = ECHO_RST;
      end
   end

   // complementary-clock registers, rising edge only
   always_ff @(posedge kn_clk) begin
      kn_ff <= nxt_kn;
   end

   // system-clock next state: toggles synchronised, then turned into pulses
   always_comb begin
      nxt_sys = sys_ff;
      nxt_sys.rd_sync = {sys_ff.rd_sync[SYNC_STAGES-1:0], k_ff.rd_tgl};
      nxt_sys.wr_sync = {sys_ff.wr_sync[SYNC_STAGES-1:0], k_ff.wr_tgl};
      nxt_sys.rd_pulse = sys_ff.rd_sync[SYNC_STAGES] ^ sys_ff.rd_sync[SYNC_STAGES-1];
      nxt_sys.wr_pulse = sys_ff.wr_sync[SYNC_STAGES] ^ sys_ff.wr_sync[SYNC_STAGES-1];
      if (rst) begin
         nxt_sys = '0;
      end
   end

   // system-clock registers
   always_ff @(posedge clk) begin
      sys_ff <= nxt_sys;
   end

   // outputs, each straight from a register
   assign read_data_k = k_ff.qk;
   assign read_data_kn = kn_ff.qkn;
   assign echo_timing_out = k_ff.echo;
   assign echo_timing_out_n = kn_ff.echo;
   assign read_valid_flag = kn_ff.valid;
   assign read_done = sys_ff.rd_pulse;
   assign write_done = sys_ff.wr_pulse;

endmodule // qrbsp_top
`default_nettype wire

// file: dv/qrbsp_properties.sv
// assertions on the sram port pins
`timescale 1ns/10ps
`default_nettype none
module qrbsp_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic k_clk,
   input wire logic kn_clk,
   input wire logic read_sel_n,
   input wire logic latency_select_pin,
   input wire logic echo_timing_out,
   input wire logic echo_timing_out_n,
   input wire logic read_valid_flag,
   input wire logic read_done,
   input wire logic write_done
);
   logic [3:0] kc_ff;
   // link edges since reset, saturating
   always_ff @(posedge k_clk) begin
      if (rst) kc_ff <= 4'h0;
      else if (kc_ff != 4'hf) kc_ff <= kc_ff + 4'h1;
   end
   property p_ek; @(posedge k_clk) disable iff (rst)
      kc_ff == 4'hf |-> $changed(echo_timing_out); endproperty
   a_ek: assert property (p_ek) else $error("echo k stuck");
   property p_ekn; @(posedge kn_clk) disable iff (rst)
      kc_ff == 4'hf |-> $changed(echo_timing_out_n); endproperty
   a_ekn: assert property (p_ekn) else $error("echo kn stuck");
   property p_vl; @(posedge k_clk) disable iff (rst)
      $rose(read_valid_flag) && latency_select_pin |-> !$past(read_sel_n, 3); endproperty
   a_vl: assert property (p_vl) else $error("long latency");
   property p_vs; @(posedge k_clk) disable iff (rst)
      $rose(read_valid_flag) && !latency_select_pin |-> !$past(read_sel_n, 2); endproperty
   a_vs: assert property (p_vs) else $error("short latency");
   property p_vd; @(posedge k_clk) disable iff (rst)
      $rose(read_valid_flag) |=> read_valid_flag; endproperty
   a_vd: assert property (p_vd) else $error("valid too short");
   property p_v0; @(posedge k_clk) disable iff (rst) kc_ff == 4'h1 |-> !read_valid_flag; endproperty
   a_v0: assert property (p_v0) else $error("valid after reset");
   property p_rd; @(posedge clk) disable iff (rst) read_done |=> !read_done; endproperty
   a_rd: assert property (p_rd) else $error("read done long");
   property p_wd; @(posedge clk) disable iff (rst) write_done |=> !write_done; endproperty
   a_wd: assert property (p_wd) else $error("write done long");
endmodule // qrbsp_chk
bind qrbsp_top qrbsp_chk u_chk (.clk, .rst, .k_clk, .kn_clk, .read_sel_n, .latency_select_pin,
   .echo_timing_out, .echo_timing_out_n, .read_valid_flag, .read_done, .write_done);
`default_nettype wire

// file: dv/qrbsp_ctrl.sv
// controller model: address, selects and write words on the link
`timescale 1ns/10ps
`default_nettype none
module qrbsp_ctrl #(
   parameter int DW = 36,
   parameter int AW = 6
) (
   input wire logic k_clk,
   input wire logic kn_clk,
   output logic [AW-1:0] addr_bus,
   output logic read_sel_n,
   output logic write_sel_n,
   output logic [DW-1:0] write_data
);
   // words 1..3 of the last write burst, still to go out after its address edge
   logic [3*DW-1:0] tail = '0;
   initial begin
      addr_bus = '0;
      read_sel_n = 1'b1;
      write_sel_n = 1'b1;
      write_data = '0;
   end
   // read slot then write slot; pins move a quarter cycle after each rise
   // each write word is set a quarter cycle ahead of the edge that samples it
   task automatic pair(input logic rd, input logic [AW-1:0] ra, input logic wr,
         input logic [AW-1:0] wa, input logic [4*DW-1:0] b);
      addr_bus = ra;
      read_sel_n = !rd;
      write_sel_n = 1'b1;
      write_data = tail[DW-1:0];
      @(posedge kn_clk) #12 write_data = tail[2*DW-1:DW];
      @(posedge k_clk) #12 addr_bus = wa;
      read_sel_n = 1'b1;
      write_sel_n = !wr;
      write_data = tail[3*DW-1:2*DW];
      @(posedge kn_clk) #12 write_data = wr ? b[DW-1:0] : DW'($urandom);
      tail = wr ? b[4*DW-1:DW] : {DW'($urandom), DW'($urandom), DW'($urandom)};
      @(posedge k_clk) #12;
   endtask
endmodule // qrbsp_ctrl
`default_nettype wire

// file: dv/qrbsp_top_test.sv
// self-checking bench for the burst sram port
`timescale 1ns/10ps
`default_nettype none
module qrbsp_top_test;
   import qrbsp_pkg::*;
   localparam int DW = DATA_W_DEF;
   localparam int AW = 6;
   logic clk = 1'b0;
   logic k_clk = 1'b0;
   logic kn_clk;
   logic rst = 1'b1;
   logic latency_select_pin = 1'b1;
   logic run = 1'b0;
   logic seen = 1'b0;
   logic [AW-1:0] addr_bus;
   logic read_sel_n, write_sel_n, echo_timing_out, echo_timing_out_n;
   logic read_valid_flag, read_done, write_done;
   logic [DW-1:0] write_data, read_data_k, read_data_kn;
   logic [DW-1:0] ek[int], ekn[int];
   logic [4*DW-1:0] mem[int];
   int kidx = 0, errors = 0, checks_done = 0, rdn = 0, wdn = 0, nrd = 0, nwr = 0;
   assign kn_clk = !k_clk;
   always #2.5 clk = !clk;
   initial #7 forever #24 k_clk = !k_clk;
   qrbsp_top #(.DATA_W(DW), .ADDR_W(AW)) uut (.clk, .rst, .k_clk, .kn_clk, .addr_bus,
      .read_sel_n, .write_sel_n, .write_data, .latency_select_pin, .read_data_k,
      .read_data_kn, .echo_timing_out, .echo_timing_out_n, .read_valid_flag, .read_done,
      .write_done);
   qrbsp_ctrl #(.DW(DW), .AW(AW)) ctl (.k_clk, .kn_clk, .addr_bus, .read_sel_n, .write_sel_n,
      .write_data);
   task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] s);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // link edge on which word i of a read taken at edge t shows
   function automatic int wk(int t, int i, bit kn);
      return t + 1 + i / 2 + (kn ? int'(latency_select_pin) : 2 * int'(latency_select_pin));
   endfunction
   function automatic logic [4*DW-1:0] rnd();
      return (4*DW)'({$urandom, $urandom, $urandom, $urandom, $urandom});
   endfunction
   // one slot pair, expectations from the reference array
   task automatic go(input logic rd, input logic [AW-1:0] ra, input logic wr,
         input logic [AW-1:0] wa, input logic [4*DW-1:0] b);
      bit kn;
      for (int i = 0; i < 4 && rd; i++) begin
         kn = (latency_select_pin == (i % 2 == 0));
         if (kn) ekn[wk(kidx + 1, i, kn)] = mem[ra][i*DW+:DW];
         else ek[wk(kidx + 1, i, kn)] = mem[ra][i*DW+:DW];
      end
      nrd += rd;
      nwr += wr;
      if (wr) mem[wa] = b;
      ctl.pair(rd, ra, wr, wa, b);
   endtask
   // random traffic at one latency, then idle and count done pulses
   task automatic pass(input logic l, input int n);
      logic [AW-1:0] wa;
      logic [AW-1:0] pw;
      latency_select_pin = l;
      repeat (4) go(0, '0, 0, '0, '0);
      {rdn, wdn, nrd, nwr} = '0;
      pw = '0;
      for (int i = 0; i < n; i++) begin
         wa = AW'($urandom % 8);
         go(i % 4 == 1 || $urandom % 2, i % 4 == 1 ? pw : AW'($urandom % 8),
            i % 4 == 0 || $urandom % 2, wa, rnd());
         pw = wa;
      end
      repeat (4) go(0, '0, 0, '0, '0);
      chk("reads", DW'(nrd), DW'(rdn));
      chk("writes", DW'(nwr), DW'(wdn));
      $display("pass latency %0d done", l);
   endtask
   // k-side words a quarter cycle after each rise
   always @(posedge k_clk) begin
      kidx++;
      #12;
      if (ek.exists(kidx)) begin
         chk("rd_k", ek[kidx], read_data_k);
         ek.delete(kidx);
      end
   end
   // kn-side words and the valid flag
   always @(posedge kn_clk) begin
      #12;
      if (run) chk("valid", DW'(ekn.exists(kidx)), DW'(read_valid_flag));
      if (ekn.exists(kidx)) begin
         chk("rd_kn", ekn[kidx], read_data_kn);
         ekn.delete(kidx);
      end
   end
   always @(posedge clk) begin
      rdn += (read_done === 1'b1);
      wdn += (write_done === 1'b1);
   end
   initial begin
      #100000;
      errors++;
      results();
   end
   // reset, slot phase probe, fill, then both latencies
   initial begin
      void'($urandom(31277));
      repeat (8) @(posedge k_clk);
      #12;
      chk("echo", '0, DW'(echo_timing_out));
      chk("echo_n", '0, DW'(echo_timing_out_n));
      chk("rd_k", '0, read_data_k);
      @(negedge clk) rst = 1'b0;
      repeat (8) @(posedge k_clk);
      #12;
      ctl.pair(1, '0, 0, '0, '0);
      repeat (8) begin
         @(posedge k_clk);
         seen |= read_valid_flag === 1'b1;
      end
      if (seen) @(posedge k_clk);
      @(posedge k_clk) #12 run = 1'b1;
      for (int i = 0; i < 8; i++) go(0, '0, 1, AW'(i), rnd());
      pass(1, 24);
      pass(0, 24);
      results();
   end
endmodule // qrbsp_top_test
`default_nettype wire
